/* File: design/reset_pin_filter.sv */
// reset pin synchroniser and pulse-length filter
`timescale 1ns/10ps
`default_nettype none
module reset_pin_filter #(
   parameter int PULSE_CYCLES = sleep_gating_pkg::RST_PULSE_CYCLES
) (
   input  wire logic clk,
   input  wire logic arst_n,
   input  wire logic pinLevel,
   input  wire logic enable,
   output var  logic resetReq
);
   import sleep_gating_pkg::*;

   localparam int CW = $clog2(PULSE_CYCLES + 1);

   logic          sync1_r, sync2_r;
   logic [CW-1:0] cnt_r, cnt_nxt;
   logic          req_r, req_nxt;

   always_comb begin
      cnt_nxt = cnt_r;
      req_nxt = 1'b0;
      if (!enable || sync2_r) begin
         cnt_nxt = '0;
      end else if (cnt_r >= CW'(PULSE_CYCLES)) begin
         req_nxt = 1'b1;
      end else begin
         cnt_nxt = cnt_r + CW'(1);
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         sync1_r <= 1'b1;
         sync2_r <= 1'b1;
         cnt_r   <= '0;
         req_r   <= 1'b0;
      end else begin
         sync1_r <= pinLevel;
         sync2_r <= sync1_r;
         cnt_r   <= cnt_nxt;
         req_r   <= req_nxt;
      end
   end

   // clockless path: a low pin with the input enabled resets at once
   assign resetReq = req_r | (enable & ~pinLevel);
endmodule // reset_pin_filter
`default_nettype wire

/* File: design/sleep_gating_pkg.sv */
// shared constants and types for the sleep and reset gating block
package sleep_gating_pkg;

   // sleep mode selector codes
   typedef enum logic [2:0] {
      MODE_IDLE       = 3'h0,
      MODE_ADC_NR     = 3'h1,
      MODE_POWER_DOWN = 3'h2,
      MODE_POWER_SAVE = 3'h3,
      MODE_STANDBY    = 3'h6
   } sleep_mode_t;

   // controller states, one-hot
   typedef enum logic [1:0] {
      ST_ACTIVE = 2'h1,
      ST_SLEEP  = 2'h2
   } pwr_state_t;

   // clock enable vector field positions
   localparam int CLK_CPU   = 0;
   localparam int CLK_IO    = 1;
   localparam int CLK_ASYNC = 2;
   localparam int CLK_ADC   = 3;
   localparam int CLK_OSC   = 4;
   localparam int CLK_W     = 5;
   localparam logic [CLK_W-1:0] CLK_ALL_ON = 5'h1F;

   // minimum reset pulse length, in ns, and its cycle count (rounded up)
   localparam int RST_PULSE_NS     = 2500;
   localparam int CLK_PERIOD_NS    = 4;
   localparam int RST_PULSE_CYCLES = (RST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // port widths, and the lowest port B pin used by the timer oscillator
   localparam int PORTB_W = 8;
   localparam int PORTC_W = 7;
   localparam int PORTD_W = 8;
   localparam int TOSC_LO = 6;

endpackage : sleep_gating_pkg

/* File: design/sleep_mode_reset_gating.sv */
// sleep mode clock gating, reset pin handling and port tri-state control
`timescale 1ns/10ps
`default_nettype none
module sleep_mode_reset_gating
   import sleep_gating_pkg::*;
#(
   parameter int PULSE_CYCLES = RST_PULSE_CYCLES
) (
   input  wire logic                      clk,
   input  wire logic                      arst_n,
   input  wire logic                      sleepReq,
   input  wire sleep_gating_pkg::sleep_mode_t sleepMode,
   input  wire logic                      wakeEvent,
   input  wire logic                      otherReset,
   input  wire logic                      reset_pin_disable_fuse,
   input  wire logic                      rcClockSelected,
   input  wire logic                      async_timer_clock_select,
   input  wire logic                      dual_use_reset_pin,
   input  wire logic [PORTB_W-1:0]        portBOutIn,
   input  wire logic [PORTB_W-1:0]        portBOeIn,
   input  wire logic [PORTC_W-1:0]        portCOutIn,
   input  wire logic [PORTC_W-1:0]        portCOeIn,
   input  wire logic [PORTD_W-1:0]        portDOutIn,
   input  wire logic [PORTD_W-1:0]        portDOeIn,
   output var  logic [CLK_W-1:0]          clkEnable,
   output var  logic                      sleeping,
   output var  logic                      resetActive,
   output var  logic                      dualPinIsGpio,
   output var  logic                      asyncOscOnPins,
   output var  logic [PORTB_W-1:0]        portBOut,
   output var  logic [PORTB_W-1:0]        portBOe,
   output var  logic [PORTC_W-1:0]        portCOut,
   output var  logic [PORTC_W-1:0]        portCOe,
   output var  logic [PORTD_W-1:0]        portDOut,
   output var  logic [PORTD_W-1:0]        portDOe
);
   import sleep_gating_pkg::*;

   pwr_state_t       state_r, state_nxt;
   logic [CLK_W-1:0] clkEn_r, clkEn_nxt;
   logic             pinReset;
   logic             gpioSel;
   logic             wakeS1_r, wakeS2_r;
   logic             wakeS1_nxt, wakeS2_nxt;

   // fuse picks the pin role
   assign gpioSel       = reset_pin_disable_fuse;
   assign dualPinIsGpio = gpioSel;

   reset_pin_filter #(.PULSE_CYCLES(PULSE_CYCLES)) u_filter (
      .clk      (clk),
      .arst_n   (arst_n),
      .pinLevel (dual_use_reset_pin),
      .enable   (~gpioSel),
      .resetReq (pinReset)
   );

   // combinational so no clock is needed
   assign resetActive = ~arst_n | otherReset | pinReset;

   // clock enables for a given sleep mode
   function automatic logic [CLK_W-1:0] modeClocks(input sleep_mode_t m);
      logic [CLK_W-1:0] e;
      e = '0;
      unique case (m)
         MODE_IDLE: begin
            e          = CLK_ALL_ON;
            e[CLK_CPU] = 1'b0;
         end
         MODE_POWER_DOWN: begin
            e = '0;
         end
         MODE_POWER_SAVE: begin
            e[CLK_ASYNC] = 1'b1;
         end
         MODE_ADC_NR: begin
            e[CLK_ASYNC] = 1'b1;
            e[CLK_ADC]   = 1'b1;
         end
         MODE_STANDBY: begin
            e[CLK_OSC] = 1'b1;
         end
         default: begin
            e          = CLK_ALL_ON;
            e[CLK_CPU] = 1'b0;
         end
      endcase
      return e;
   endfunction

   // controller next state
   always_comb begin
      state_nxt = state_r;
      clkEn_nxt = clkEn_r;
      unique case (state_r)
         ST_ACTIVE: begin
            if (sleepReq && !wakeS2_r) begin
               state_nxt = ST_SLEEP;
               clkEn_nxt = modeClocks(sleepMode);
            end
         end
         ST_SLEEP: begin
            if (wakeS2_r) begin
               state_nxt = ST_ACTIVE;
               clkEn_nxt = CLK_ALL_ON;
            end
         end
         default: begin
            state_nxt = ST_ACTIVE;
            clkEn_nxt = CLK_ALL_ON;
         end
      endcase
      if (resetActive) begin
         state_nxt = ST_ACTIVE;
         clkEn_nxt = CLK_ALL_ON;
      end
   end

   // controller state registers
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state_r <= ST_ACTIVE;
         clkEn_r <= CLK_ALL_ON;
      end else begin
         state_r <= state_nxt;
         clkEn_r <= clkEn_nxt;
      end
   end

   // wake event synchroniser
   always_comb begin
      wakeS1_nxt = wakeEvent;
      wakeS2_nxt = wakeS1_r;
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         wakeS1_r <= 1'b0;
         wakeS2_r <= 1'b0;
      end else begin
         wakeS1_r <= wakeS1_nxt;
         wakeS2_r <= wakeS2_nxt;
      end
   end

   // controller outputs
   assign clkEnable = clkEn_r;
   always_comb begin
      unique case (state_r)
         ST_SLEEP: sleeping = 1'b1;
         default:  sleeping = 1'b0;
      endcase
   end

   // oscillator pins follow the clock choice
   assign asyncOscOnPins = rcClockSelected & async_timer_clock_select;

   // port B, pin by pin
   for (genvar gb = 0; gb < PORTB_W; gb++) begin : g_portB
      logic oscPin;
      logic oeB;
      // the upper pins feed the timer oscillator
      assign oscPin = asyncOscOnPins & ((gb >= TOSC_LO) ? 1'b1 : 1'b0);
      always_comb begin
         oeB = portBOeIn[gb];
         if (oscPin) begin
            oeB = 1'b0;
         end
         // released under any reset
         if (resetActive) begin
            oeB = 1'b0;
         end
      end
      // data passes straight through
      assign portBOut[gb] = portBOutIn[gb];
      assign portBOe[gb]  = oeB;
   end

   // port C, pin by pin
   for (genvar gc = 0; gc < PORTC_W; gc++) begin : g_portC
      logic rstPin;
      logic oeC;
      // the top pin is the reset input unless the fuse is set
      assign rstPin = ~gpioSel & ((gc == PORTC_W - 1) ? 1'b1 : 1'b0);
      always_comb begin
         oeC = portCOeIn[gc];
         if (rstPin) begin
            oeC = 1'b0;
         end
         // released under any reset
         if (resetActive) begin
            oeC = 1'b0;
         end
      end
      // data passes straight through
      assign portCOut[gc] = portCOutIn[gc];
      assign portCOe[gc]  = oeC;
   end

   // port D, pin by pin, no shared pins
   for (genvar gd = 0; gd < PORTD_W; gd++) begin : g_portD
      logic oeD;
      always_comb begin
         oeD = portDOeIn[gd];
         // released under any reset
         if (resetActive) begin
            oeD = 1'b0;
         end
      end
      // data passes straight through
      assign portDOut[gd] = portDOutIn[gd];
      assign portDOe[gd]  = oeD;
   end
endmodule // sleep_mode_reset_gating
`default_nettype wire

/* File: tb/reset_source_model.sv */
// external reset source on the dual-use pin, pulled up when idle
`timescale 1ns/10ps
`default_nettype none
module reset_source_model (
   input  wire logic clk,
   output var  logic pinLevel
);
   initial pinLevel = 1'b1;
   // low drives the pin, release returns to the pull-up level
   task automatic setLow(input logic low);
      @(negedge clk) pinLevel = ~low;
   endtask
endmodule // reset_source_model
`default_nettype wire

/* File: tb/sleep_gating_properties.sv */
// port assertions for the sleep and reset gating block
`timescale 1ns/10ps
`default_nettype none
module sleep_gating_properties
   import sleep_gating_pkg::*;
(
   input wire logic clk, arst_n, wakeEvent, reset_pin_disable_fuse, dual_use_reset_pin,
   input wire logic rcClockSelected, async_timer_clock_select,
   input wire logic sleeping, resetActive, dualPinIsGpio, asyncOscOnPins,
   input wire sleep_mode_t sleepMode,
   input wire logic [CLK_W-1:0] clkEnable,
   input wire logic [PORTB_W-1:0] portBOe,
   input wire logic [PORTC_W-1:0] portCOe,
   input wire logic [PORTD_W-1:0] portDOe
);
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   AST_IDLE: assert property ($rose(sleeping) && $past(sleepMode) == MODE_IDLE |-> clkEnable == 5'h1E)
      else $error("idle clocks");
   AST_PDOWN: assert property ($rose(sleeping) && $past(sleepMode) == MODE_POWER_DOWN |-> clkEnable == 5'h00)
      else $error("power-down clocks");
   AST_PSAVE: assert property ($rose(sleeping) && $past(sleepMode) == MODE_POWER_SAVE |-> clkEnable == 5'h04)
      else $error("power-save clocks");
   AST_ADCNR: assert property ($rose(sleeping) && $past(sleepMode) == MODE_ADC_NR |-> clkEnable == 5'h0C)
      else $error("adc clocks");
   AST_STBY: assert property ($rose(sleeping) && $past(sleepMode) == MODE_STANDBY |-> clkEnable == 5'h10)
      else $error("standby clocks");
   AST_TRI: assert property (resetActive |-> portBOe == 8'h00 && portCOe == 7'h00 && portDOe == 8'h00)
      else $error("ports driven in reset");
   AST_GPIO: assert property (dualPinIsGpio == reset_pin_disable_fuse && (dualPinIsGpio || !portCOe[6]))
      else $error("dual pin use");
   AST_PIN: assert property (!reset_pin_disable_fuse && !dual_use_reset_pin |-> resetActive)
      else $error("pin reset missed");
   AST_TOSC: assert property (asyncOscOnPins == (rcClockSelected && async_timer_clock_select)
      && (!asyncOscOnPins || portBOe[7:6] == 2'h0))
      else $error("oscillator pins");
   AST_WAKE: assert property (sleeping && wakeEvent ##1 wakeEvent [*2] |=> !sleeping && clkEnable == 5'h1F)
      else $error("wake late");
   AST_FORCE: assert property (resetActive |=> !sleeping && clkEnable == 5'h1F)
      else $error("reset not forcing");
endmodule // sleep_gating_properties
`default_nettype wire

/* File: tb/tb_top.sv */
// self-checking bench for the sleep and reset gating block
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   import sleep_gating_pkg::*;
   logic clk = 1'b0, arst_n = 1'b0, sleepReq = 1'b0, wakeEvent = 1'b0, otherReset = 1'b0;
   logic fuse = 1'b0, rcSel = 1'b0, asSel = 1'b0, pin, slp, rstAct, gpio, oscOn;
   sleep_mode_t mode = MODE_IDLE;
   logic [7:0] oeIn = 8'hFF, outData = 8'hA5, bOe, dOe, bOut, dOut;
   logic [6:0] cOe, cOut;
   logic [4:0] clkEn;
   int errorCnt = 0, samplesChecked = 0;
   initial forever #2 clk = ~clk;
   reset_source_model src (.clk(clk), .pinLevel(pin));
   sleep_mode_reset_gating #(.PULSE_CYCLES(4)) dut (.clk(clk), .arst_n(arst_n), .sleepReq(sleepReq),
      .sleepMode(mode), .wakeEvent(wakeEvent), .otherReset(otherReset), .reset_pin_disable_fuse(fuse),
      .rcClockSelected(rcSel), .async_timer_clock_select(asSel), .dual_use_reset_pin(pin),
      .portBOutIn(outData), .portBOeIn(oeIn), .portCOutIn(outData[6:0]), .portCOeIn(oeIn[6:0]),
      .portDOutIn(~outData), .portDOeIn(oeIn), .clkEnable(clkEn), .sleeping(slp), .resetActive(rstAct),
      .dualPinIsGpio(gpio), .asyncOscOnPins(oscOn), .portBOut(bOut), .portBOe(bOe), .portCOut(cOut),
      .portCOe(cOe), .portDOut(dOut), .portDOe(dOe));
   task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
      samplesChecked++;
      if (got !== exp) begin
         errorCnt++;
         $display("Error %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic completeRun();
      $display("checks %0d errors %0d", samplesChecked, errorCnt);
      if (errorCnt == 0 && samplesChecked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic modeRun(input sleep_mode_t m, input logic [4:0] e);
      repeat (3) @(negedge clk);
      mode = m;
      sleepReq = 1'b1;
      @(negedge clk) sleepReq = 1'b0;
      chk("sleep clocks", {3'h0, e}, {3'h0, clkEn});
      wakeEvent = 1'b1;
      repeat (3) @(negedge clk);
      wakeEvent = 1'b0;
      chk("wake clocks", 8'h1F, {3'h0, clkEn});
   endtask
   task automatic refuseRun();
      @(negedge clk) wakeEvent = 1'b1;
      repeat (3) @(negedge clk);
      sleepReq = 1'b1;
      @(negedge clk) sleepReq = 1'b0;
      wakeEvent = 1'b0;
      chk("refused sleep", 8'h00, {7'h0, slp});
   endtask
   task automatic otherRun();
      repeat (3) @(negedge clk);
      sleepReq = 1'b1;
      @(negedge clk) sleepReq = 1'b0;
      otherReset = 1'b1;
      #1 chk("reset d oe", 8'h00, dOe);
      @(negedge clk) otherReset = 1'b0;
      chk("reset clocks", 8'h1F, {3'h0, clkEn});
   endtask
   task automatic pinRun(input logic f);
      fuse = f;
      src.setLow(1'b1);
      #1 chk("pin reset", {7'h0, ~f}, {7'h0, rstAct});
      chk("pin role", {7'h0, f}, {7'h0, gpio});
      chk("port b oe", f ? 8'hFF : 8'h00, bOe);
      repeat (8) @(negedge clk);
      src.setLow(1'b0);
      repeat (4) @(negedge clk);
      chk("port c oe", {1'b0, f ? 7'h7F : 7'h3F}, {1'b0, cOe});
   endtask
   task automatic oscRun(input logic r, input logic a);
      @(negedge clk) rcSel = r;
      asSel = a;
      #1 chk("osc port b oe", (r & a) ? 8'h3F : 8'hFF, bOe);
      chk("osc select", {7'h0, r & a}, {7'h0, oscOn});
   endtask
   task automatic passRun(input logic [7:0] d, input logic [7:0] oe);
      @(negedge clk) outData = d;
      oeIn = oe;
      #1 chk("port b out", d, bOut);
      chk("port c out", {1'b0, d[6:0]}, {1'b0, cOut});
      chk("port d out", ~d, dOut);
      chk("port b oe", oe, bOe);
      chk("port c oe", {1'b0, oe[6:0]}, {1'b0, cOe});
      chk("port d oe", oe, dOe);
      otherReset = 1'b1;
      #1 chk("reset b oe", 8'h00, bOe);
      chk("reset c oe", 8'h00, {1'b0, cOe});
      @(negedge clk) otherReset = 1'b0;
   endtask
   initial begin
      repeat (12) @(negedge clk);
      chk("oe in reset", 8'h00, dOe);
      arst_n = 1'b1;
      modeRun(MODE_IDLE, 5'h1E);
      modeRun(MODE_POWER_DOWN, 5'h00);
      modeRun(MODE_POWER_SAVE, 5'h04);
      modeRun(MODE_ADC_NR, 5'h0C);
      modeRun(MODE_STANDBY, 5'h10);
      refuseRun();
      otherRun();
      pinRun(1'b0);
      pinRun(1'b1);
      oscRun(1'b1, 1'b1);
      oscRun(1'b1, 1'b0);
      oscRun(1'b0, 1'b1);
      passRun(8'h5A, 8'h0F);
      passRun(8'hC3, 8'hF0);
      completeRun();
   end
   initial begin
      #4000;
      errorCnt++;
      completeRun();
   end
endmodule // tb_top
bind sleep_mode_reset_gating sleep_gating_properties props (.*);
`default_nettype wire
